// *** design/rifsc_defs.vh ***
// Purpose: Constants for the interrupt routing and flag block
// Assumes: Byte-wide registers at their printed indices
// Notes:   Definitions only
`ifndef RIFSC_DEFS_VH
`define RIFSC_DEFS_VH
// ==========================================
// Register offsets
`define RIFSC_ADDR_ROUTE     8'h0D
`define RIFSC_ADDR_FILL      8'h0E
`define RIFSC_ADDR_THRESH    8'h0F
// ==========================================
// Reset values
`define RIFSC_RST_ROUTE      8'h00
`define RIFSC_RST_FILL       8'h01
`define RIFSC_RST_THRESH     8'h00
// ==========================================
// Field positions, routing register
`define RIFSC_B_OVERRUN      0
`define RIFSC_B_NOT_EMPTY    1
`define RIFSC_B_FULL         2
`define RIFSC_B_TX_B_SEL     3
// Field positions, fill register
`define RIFSC_B_LOCK_EN      0
`define RIFSC_B_LOCK         1
`define RIFSC_B_STRENGTH     2
`define RIFSC_B_STR_EN       3
`define RIFSC_B_TX_START     4
`define RIFSC_B_TX_DONE      5
`define RIFSC_B_FILL_CTRL    6
`define RIFSC_B_FILL_METHOD  7
// ==========================================
// Data path modes and device modes
`define RIFSC_DM_CONT        2'h0
`define RIFSC_DM_BUF         2'h1
`define RIFSC_OM_RX          2'h0
`define RIFSC_OM_STBY        2'h1
`define RIFSC_OM_TX          2'h2
`endif

// *** design/rifsc_top.v ***
// Purpose: Interrupt line routing, FIFO and status flags of a packet radio
// Assumes: Single clock, synchronous inputs, plain register port
// Notes:   Event inputs are one-cycle pulses; levels are levels
`include "rifsc_defs.vh"
`default_nettype none

module rifsc_top
(
  // Clock and reset
  input  wire       core_clk_i,
  input  wire       srst_i,
  // Register port
  input  wire [7:0] reg_addr_i,
  input  wire [7:0] reg_wdata_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  output reg  [7:0] reg_rdata_o,
  // Operating state
  input  wire [1:0] data_path_mode_i,
  input  wire [1:0] op_mode_i,
  input  wire       addr_filter_en_i,
  // Internal events and levels
  input  wire       pattern_detect_i,
  input  wire       address_match_i,
  input  wire       byte_written_i,
  input  wire       payload_complete_i,
  input  wire       checksum_good_i,
  input  wire       fifo_level_i,
  input  wire       recovered_bit_clock_i,
  input  wire       fifo_full_i,
  input  wire       fifo_empty_i,
  input  wire       fifo_overrun_i,
  input  wire       last_bit_shifted_i,
  input  wire       tx_begin_i,
  input  wire [7:0] strength_meas_i,
  input  wire       strength_valid_i,
  input  wire       synth_locked_i,
  // Outputs
  output wire       interrupt_line_a_o,
  output wire       interrupt_line_b_o,
  output wire       lock_pin_o,
  output reg        fifo_flush_o,
  output wire       fifo_fill_en_o,
  output wire       tx_start_o
);

  // ==========================================
  // Registers
  reg  [1:0] line_a_sel_reg;
  reg  [1:0] line_b_sel_reg;
  reg        tx_b_sel_reg;
  reg        overrun_reg;
  reg        fill_method_reg;
  reg        fill_ctrl_reg;
  reg        tx_done_reg;
  reg        tx_start_sel_reg;
  reg        str_en_reg;
  reg        strength_reg;
  reg        lock_reg;
  reg        lock_en_reg;
  reg  [7:0] strength_threshold_reg;
  reg  [7:0] rdata_next;

  wire       wr_route;
  wire       wr_fill;
  wire       wr_thresh;
  wire       is_buf;
  wire       is_pkt;
  wire       in_tx;
  wire       not_empty_flag;
  wire       strength_event;
  wire       clr_overrun;
  wire       clr_strength;
  wire       clr_lock;
  wire       manual_fill;
  wire       rearm_fill;

  // Address decode shared by write and read paths
  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  assign wr_route  = reg_wr_i && hit(reg_addr_i, `RIFSC_ADDR_ROUTE);
  assign wr_fill   = reg_wr_i && hit(reg_addr_i, `RIFSC_ADDR_FILL);
  assign wr_thresh = reg_wr_i && hit(reg_addr_i, `RIFSC_ADDR_THRESH);
  assign clr_overrun  = wr_route && reg_wdata_i[`RIFSC_B_OVERRUN];
  assign clr_strength = wr_fill && reg_wdata_i[`RIFSC_B_STRENGTH];
  assign clr_lock     = wr_fill && reg_wdata_i[`RIFSC_B_LOCK];
  // Method written together with the fill bit takes effect at once
  assign manual_fill  = wr_fill ? reg_wdata_i[`RIFSC_B_FILL_METHOD] : fill_method_reg;
  assign rearm_fill   = wr_fill && reg_wdata_i[`RIFSC_B_FILL_CTRL] && !overrun_reg;
  assign is_buf    = (data_path_mode_i == `RIFSC_DM_BUF);
  assign is_pkt    = data_path_mode_i[1];
  assign in_tx     = (op_mode_i == `RIFSC_OM_TX);

  assign not_empty_flag = ~fifo_empty_i;
  // Threshold compare, gated by the enable bit
  assign strength_event = str_en_reg && strength_valid_i &&
                          (strength_meas_i > strength_threshold_reg);

  // Write-one-to-clear with set winning over clear
  function wclr;
    input cur;
    input set;
    input clr;
    begin
      wclr = set | (cur & ~clr);
    end
  endfunction

  // ==========================================
  // Routing register fields
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      line_a_sel_reg <= 2'h0;
      line_b_sel_reg <= 2'h0;
      tx_b_sel_reg   <= 1'b0;
    end
    else if (wr_route)
    begin
      line_a_sel_reg <= reg_wdata_i[7:6];
      line_b_sel_reg <= reg_wdata_i[5:4];
      tx_b_sel_reg   <= reg_wdata_i[`RIFSC_B_TX_B_SEL];
    end
  end

  // ==========================================
  // Fill register configuration fields
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      fill_method_reg  <= 1'b0;
      tx_start_sel_reg <= 1'b0;
      str_en_reg       <= 1'b0;
      lock_en_reg      <= 1'b1;
    end
    else if (wr_fill)
    begin
      fill_method_reg  <= reg_wdata_i[`RIFSC_B_FILL_METHOD];
      tx_start_sel_reg <= reg_wdata_i[`RIFSC_B_TX_START];
      str_en_reg       <= reg_wdata_i[`RIFSC_B_STR_EN];
      lock_en_reg      <= reg_wdata_i[`RIFSC_B_LOCK_EN];
    end
  end

  // ==========================================
  // Strength threshold
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      strength_threshold_reg <= `RIFSC_RST_THRESH;
    end
    else if (wr_thresh)
    begin
      strength_threshold_reg <= reg_wdata_i;
    end
  end

  // ==========================================
  // Overrun flag and FIFO flush
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      overrun_reg  <= 1'b0;
      fifo_flush_o <= 1'b0;
    end
    else
    begin
      overrun_reg  <= wclr(overrun_reg, fifo_overrun_i, clr_overrun);
      fifo_flush_o <= clr_overrun;
    end
  end

  // ==========================================
  // Strength and lock flags
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      strength_reg <= 1'b0;
      lock_reg     <= 1'b0;
    end
    else
    begin
      strength_reg <= wclr(strength_reg, strength_event, clr_strength);
      lock_reg     <= wclr(lock_reg, synth_locked_i, clr_lock);
    end
  end

  // ==========================================
  // Transmit finished flag
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      tx_done_reg <= 1'b0;
    end
    else if (last_bit_shifted_i)
    begin
      tx_done_reg <= 1'b1;
    end
    else if (tx_begin_i)
    begin
      // A new transmission starts with the flag low
      tx_done_reg <= 1'b0;
    end
  end

  // ==========================================
  // Fill control
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      fill_ctrl_reg <= 1'b0;
    end
    else if (manual_fill)
    begin
      if (wr_fill)
      begin
        fill_ctrl_reg <= reg_wdata_i[`RIFSC_B_FILL_CTRL];
      end
    end
    else if (pattern_detect_i && is_buf)
    begin
      // Pattern wins over a clear in the same cycle
      fill_ctrl_reg <= 1'b1;
    end
    else if (rearm_fill)
    begin
      fill_ctrl_reg <= 1'b0;
    end
  end

  // ==========================================
  // Read data register
  always @(posedge core_clk_i)
  begin
    if (srst_i)
    begin
      reg_rdata_o <= 8'h00;
    end
    else
    begin
      reg_rdata_o <= rdata_next;
    end
  end

  // ==========================================
  // Read mux
  always @*
  begin
    rdata_next = 8'h00;
    if (reg_rd_i)
    begin
      if (hit(reg_addr_i, `RIFSC_ADDR_ROUTE))
      begin
        rdata_next = {line_a_sel_reg, line_b_sel_reg, tx_b_sel_reg,
                      fifo_full_i, not_empty_flag, overrun_reg};
      end
      else if (hit(reg_addr_i, `RIFSC_ADDR_FILL))
      begin
        rdata_next = {fill_method_reg, fill_ctrl_reg, tx_done_reg, tx_start_sel_reg,
                      str_en_reg, strength_reg, lock_reg, lock_en_reg};
      end
      else if (hit(reg_addr_i, `RIFSC_ADDR_THRESH))
      begin
        rdata_next = strength_threshold_reg;
      end
    end
  end

  // ==========================================
  // Line A routing
  reg line_a;
  always @*
  begin
    line_a = 1'b0;
    if (in_tx)
    begin
      if (is_pkt && !tx_start_sel_reg)
        line_a = fifo_level_i;
      else if (is_buf || is_pkt)
        line_a = not_empty_flag;
      else
        line_a = pattern_detect_i;
    end
    else if (data_path_mode_i == `RIFSC_DM_CONT)
      line_a = (line_a_sel_reg == 2'h1) ? strength_reg : pattern_detect_i;
    else
    begin
      case (line_a_sel_reg)
        2'h0: line_a = is_pkt ? payload_complete_i : 1'b0;
        2'h1: line_a = byte_written_i;
        2'h2: line_a = not_empty_flag;
        default: line_a = (is_pkt && addr_filter_en_i) ? address_match_i
                                                       : pattern_detect_i;
      endcase
    end
  end

  // ==========================================
  // Line B routing
  reg line_b;
  always @*
  begin
    line_b = 1'b0;
    if (data_path_mode_i == `RIFSC_DM_CONT)
      line_b = recovered_bit_clock_i;
    else if (in_tx)
      line_b = tx_b_sel_reg ? tx_done_reg : fifo_full_i;
    else
    begin
      case (line_b_sel_reg)
        2'h0: line_b = is_pkt ? checksum_good_i : 1'b0;
        2'h1: line_b = fifo_full_i;
        2'h2: line_b = strength_reg;
        default: line_b = fifo_level_i;
      endcase
    end
  end

  // ==========================================
  // Transmit start condition
  reg tx_start;
  always @*
  begin
    tx_start = 1'b0;
    if (tx_start_sel_reg)
    begin
      tx_start = not_empty_flag;
    end
    else if (is_pkt)
    begin
      tx_start = fifo_level_i;
    end
    else
    begin
      tx_start = fifo_full_i;
    end
  end

  assign interrupt_line_a_o = line_a;
  assign interrupt_line_b_o = line_b;
  assign lock_pin_o         = lock_en_reg ? lock_reg : 1'b1;
  // Auto fill runs while flag set; outside buffered mode filling is free
  assign fifo_fill_en_o     = is_buf ? fill_ctrl_reg : 1'b1;
  assign tx_start_o         = tx_start;

endmodule // rifsc_top

`default_nettype wire

// *** tb/rifsc_host.sv ***
// Purpose: Host microcontroller model on the register port
// Assumes: Read data stand only in the cycle after the strobe
// Notes:   Strobes one cycle, changed just after rising edges
`default_nettype none
module rifsc_host
(
  // Clock
  input  wire logic       core_clk_i,
  // Register port
  output var  logic [7:0] addr_o = 8'h00,
  output var  logic [7:0] wdata_o = 8'h00,
  output var  logic       wr_o = 1'b0,
  output var  logic       rd_o = 1'b0,
  input  wire logic [7:0] rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge core_clk_i);
    wr_o <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge core_clk_i);
    rd_o <= 1'b0;
    #1 d = rdata_i;
  endtask
endmodule // rifsc_host
`default_nettype wire

// *** tb/rifsc_top_bench.sv ***
// Purpose: Register-level tests of the routing and flag block
// Assumes: Host model drives the register port
// Notes:   Event sources held as levels while routing is checked
`default_nettype none
module rifsc_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, srst = 1'b1, bclk = 1'b0, pat = 1'b0, byt = 1'b0, pay = 1'b0, full = 1'b0, empty = 1'b1;
  logic ovr = 1'b0, last = 1'b0, sv = 1'b0, lock = 1'b0, lna, lnb, lpin, flush;
  logic [1:0] dm = 2'h0, om = 2'h0;
  logic [7:0] meas = 8'h00, a, wd, rdat;
  logic       wr, rd;
  int         fails = 0, checks = 0;
  initial forever #50 clk = ~clk;
  always @(posedge clk) bclk <= ~bclk;
  rifsc_host host_u (.core_clk_i(clk), .addr_o(a), .wdata_o(wd), .wr_o(wr), .rd_o(rd), .rdata_i(rdat));
  rifsc_top dut_u (.core_clk_i(clk), .srst_i(srst), .reg_addr_i(a), .reg_wdata_i(wd), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdat), .data_path_mode_i(dm), .op_mode_i(om), .addr_filter_en_i(1'b0),
    .pattern_detect_i(pat), .address_match_i(1'b0), .byte_written_i(byt), .payload_complete_i(pay),
    .checksum_good_i(1'b0), .fifo_level_i(1'b0), .recovered_bit_clock_i(bclk), .fifo_full_i(full),
    .fifo_empty_i(empty), .fifo_overrun_i(ovr), .last_bit_shifted_i(last), .tx_begin_i(1'b0),
    .strength_meas_i(meas), .strength_valid_i(sv), .synth_locked_i(lock), .interrupt_line_a_o(lna),
    .interrupt_line_b_o(lnb), .lock_pin_o(lpin), .fifo_flush_o(flush), .fifo_fill_en_o(), .tx_start_o());
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] ad, input logic [7:0] exp);
    logic [7:0] d;
    host_u.rd(ad, d);
    chk(d, exp);
  endtask
  task automatic final_report;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial
  begin
    #1000000;
    fails++;
    final_report;
  end
  // ==========================================
  // Test sequence
  initial
  begin
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    rdc(8'h0D, 8'h00);
    rdc(8'h0E, 8'h01);
    rdc(8'h0F, 8'h00);
    rdc(8'h10, 8'h00);
    full <= 1'b1;
    empty <= 1'b0;
    rdc(8'h0D, 8'h06);
    $display("reset test done");
    host_u.wr(8'h0F, 8'h80);
    rdc(8'h0F, 8'h80);
    host_u.wr(8'h0E, 8'h09);
    meas <= 8'h81;
    sv <= 1'b1;
    @(posedge clk);
    sv <= 1'b0;
    rdc(8'h0E, 8'h0D);
    host_u.wr(8'h0E, 8'h09);
    rdc(8'h0E, 8'h0D);
    dm <= 2'h2;
    host_u.wr(8'h0D, 8'h20);
    #1 chk(lnb, 1'b1);
    host_u.wr(8'h0E, 8'h0D);
    rdc(8'h0E, 8'h09);
    $display("strength test done");
    ovr <= 1'b1;
    @(posedge clk);
    ovr <= 1'b0;
    rdc(8'h0D, 8'h27);
    host_u.wr(8'h0D, 8'h20);
    rdc(8'h0D, 8'h27);
    host_u.wr(8'h0D, 8'h21);
    #1 chk(flush, 1'b1);
    rdc(8'h0D, 8'h26);
    lock <= 1'b1;
    @(posedge clk);
    lock <= 1'b0;
    rdc(8'h0E, 8'h0B);
    chk(lpin, 1'b1);
    host_u.wr(8'h0E, 8'h0B);
    #1 chk(lpin, 1'b0);
    rdc(8'h0E, 8'h09);
    host_u.wr(8'h0E, 8'h08);
    #1 chk(lpin, 1'b1);
    rdc(8'h0E, 8'h08);
    $display("flag test done");
    for (int m = 2; m > 0; m--)
      for (int c = 0; c < 4; c++)
      begin
        dm <= m[1:0];
        host_u.wr(8'h0D, {c[1:0], 6'h00});
        pay <= (c == 0);
        byt <= (c == 1);
        empty <= (c != 2);
        pat <= (c == 3);
        @(posedge clk);
        #1 chk(lna, (m == 2 || c != 0));
      end
    pat <= 1'b0;
    rdc(8'h0E, 8'h48);
    host_u.wr(8'h0E, 8'h48);
    rdc(8'h0E, 8'h08);
    $display("routing test done");
    om <= 2'h2;
    full <= 1'b0;
    empty <= 1'b0;
    host_u.wr(8'h0D, 8'h08);
    last <= 1'b1;
    @(posedge clk);
    last <= 1'b0;
    rdc(8'h0E, 8'h28);
    chk(lnb, 1'b1);
    chk(lna, 1'b1);
    host_u.wr(8'h0E, 8'hC8);
    rdc(8'h0E, 8'hE8);
    host_u.wr(8'h0E, 8'h88);
    rdc(8'h0E, 8'hA8);
    $display("transmit test done");
    final_report;
  end
endmodule // rifsc_top_bench
`default_nettype wire

// *** tb/rifsc_top_sva.sv ***
// Purpose: Port-level checks of the routing and flag block
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound into every rifsc_top
`default_nettype none
module rifsc_chk
(
  // Clock, reset, register port
  input wire logic       core_clk_i,
  input wire logic       srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // Routing and FIFO
  input wire logic [1:0] data_path_mode_i,
  input wire logic       recovered_bit_clock_i,
  input wire logic       fifo_full_i,
  input wire logic       fifo_empty_i,
  input wire logic       interrupt_line_b_o,
  input wire logic       fifo_flush_o,
  input wire logic       fifo_fill_en_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // ==========================================
  // Register port
  a_rdata_idle_zero: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00) else $error("read data not idle");
  a_unmapped_reads_zero: assert property (reg_rd_i && (reg_addr_i < 8'h0D || reg_addr_i > 8'h0F) |=>
    reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_thresh_write_read: assert property (reg_wr_i && reg_addr_i == 8'h0F ##1 reg_rd_i && reg_addr_i == 8'h0F |=>
    reg_rdata_o == $past(reg_wdata_i, 2)) else $error("threshold readback wrong");
  a_full_flag_read: assert property (reg_rd_i && reg_addr_i == 8'h0D |=>
    reg_rdata_o[2] == $past(fifo_full_i)) else $error("full flag wrong");
  a_not_empty_read: assert property (reg_rd_i && reg_addr_i == 8'h0D |=>
    reg_rdata_o[1] == !$past(fifo_empty_i)) else $error("not-empty flag wrong");
  // ==========================================
  // FIFO control and routing
  a_flush_after_clear: assert property (reg_wr_i && reg_addr_i == 8'h0D && reg_wdata_i[0] |=>
    fifo_flush_o ##1 (!fifo_flush_o || $past(reg_wr_i && reg_addr_i == 8'h0D && reg_wdata_i[0])))
    else $error("flush pulse missing");
  a_flush_has_cause: assert property (fifo_flush_o |->
    $past(reg_wr_i && reg_addr_i == 8'h0D && reg_wdata_i[0])) else $error("flush without clear");
  a_line_b_bitclk: assert property (data_path_mode_i == 2'h0 |->
    interrupt_line_b_o == recovered_bit_clock_i) else $error("line b not bit clock");
  a_fill_outside_buf: assert property (data_path_mode_i != 2'h1 |-> fifo_fill_en_o) else $error("fill gated");
  c_flush: cover property (fifo_flush_o);
  c_thresh_read: cover property (reg_rd_i && reg_addr_i == 8'h0F);
  c_bitclk_high: cover property (data_path_mode_i == 2'h0 && interrupt_line_b_o);
endmodule // rifsc_chk
bind rifsc_top rifsc_chk chk_u (.core_clk_i, .srst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .data_path_mode_i, .recovered_bit_clock_i, .fifo_full_i, .fifo_empty_i, .interrupt_line_b_o,
  .fifo_flush_o, .fifo_fill_en_o);
`default_nettype wire
